// [rtl/lpcs_device.sv]
/*
  Device end of the sequencer: power-on reset delay, periphery and full
  configuration tracking, transceiver reset, image-update path selection.
  Assumes supply monitors and configuration engine report synchronously.
*/
`timescale 1ns/1ps
`default_nettype none
module lpcs_device
  import lpcs_pkg::*;
#(
  parameter int unsigned TICKS_PER_MS = LPCS_TICKS_PER_MS
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  lpcs_link_if.device link,
  input wire logic supplies_good_in,
  input wire logic fast_por_select_in,
  input wire lpcs_mode_type mode_in,
  input wire logic periphery_done_in,
  input wire logic full_config_done_in,
  input wire logic fabric_loaded_in,
  output logic device_reset_n_out,
  output logic xcvr_reset_n_out,
  output logic config_start_out,
  output logic link_image_update_out,
  output logic remote_upgrade_out,
  output logic partial_reconfig_en_out,
  output logic link_fabric_config_en_out,
  output logic link_user_traffic_out,
  output logic deadline_miss_out,
  output logic l0_late_out
);
  typedef enum logic [2:0] {
    LPCS_D_SUPPLY,
    LPCS_D_POR,
    LPCS_D_CONFIG,
    LPCS_D_WAIT_FABRIC,
    LPCS_D_USER
  } lpcs_dstate_type;

  typedef struct packed {
    lpcs_dstate_type st;
    logic [24:0] tick;
    logic [LPCS_MS_W-1:0] ms_up;
    logic [LPCS_MS_W-1:0] ms_por;
    logic por_done;
    logic xcvr_rst_n;
    logic cfg_done;
    logic train_ready;
    logic upd_link;
    logic upd_remote;
    logic fab_link;
    logic traffic;
    logic miss;
    logic l0_late;
    logic start;
  } lpcs_dev_type;

  lpcs_dev_type r;
  lpcs_dev_type next_r;
  logic ms_pulse;
  logic periph_ok;
  logic [LPCS_MS_W-1:0] por_limit;

  always_comb begin
    next_r = r;
    // One tick counter serves every window, so all deadlines share a time base
    ms_pulse = (r.tick == 25'(TICKS_PER_MS - 1));
    if (ms_pulse) begin
      next_r.tick = '0;
    end else begin
      next_r.tick = r.tick + 25'h0000001;
    end
    // Uptime saturates rather than wraps, so a late link stays late
    if (ms_pulse && r.ms_up != {LPCS_MS_W{1'b1}}) begin
      next_r.ms_up = r.ms_up + 8'h01;
    end
    next_r.start = 1'b0;
    // Init mode only loads periphery, so any scheme completes early enough
    if (mode_in == LPCS_MODE_INIT_UPDATE) begin
      periph_ok = periphery_done_in;
    end else begin
      periph_ok = full_config_done_in;
    end
    // Slow delay is kept for systems that need no link wake-up budget
    if (fast_por_select_in) begin
      por_limit = LPCS_MS_W'(LPCS_FAST_POR_MS);
    end else begin
      por_limit = LPCS_MS_W'(LPCS_SLOW_POR_MS);
    end
    case (r.st)
      LPCS_D_SUPPLY: begin
        // Time is measured from supply good, the start of power-up
        next_r.ms_up = '0;
        next_r.tick = '0;
        if (supplies_good_in) begin
          next_r.st = LPCS_D_POR;
          next_r.ms_por = '0;
        end
      end
      LPCS_D_POR: begin
        if (ms_pulse) begin
          next_r.ms_por = r.ms_por + 8'h01;
        end
        if (ms_pulse && r.ms_por + 8'h01 >= por_limit) begin
          next_r.st = LPCS_D_CONFIG;
          next_r.por_done = 1'b1;
          next_r.start = 1'b1;
        end
      end
      LPCS_D_CONFIG: begin
        if (periph_ok) begin
          next_r.train_ready = 1'b1;
          if (mode_in == LPCS_MODE_INIT_UPDATE) begin
            next_r.st = LPCS_D_WAIT_FABRIC;
          end else begin
            next_r.st = LPCS_D_USER;
            next_r.cfg_done = 1'b1;
          end
        end else if (r.ms_up >= 8'(LPCS_CONFIG_DONE_MAX_MS)) begin
          next_r.miss = 1'b1;
        end
      end
      LPCS_D_WAIT_FABRIC: begin
        // Fabric arrives over the link, so it cannot complete before L0
        if (fabric_loaded_in && link.link_active) begin
          next_r.st = LPCS_D_USER;
          next_r.cfg_done = 1'b1;
        end
      end
      default: begin
      end
    endcase
    // A supply dropout restarts the power-up sequence; the sticky miss and l0_late flags keep their value
    if (!supplies_good_in) begin
      next_r.st = LPCS_D_SUPPLY;
      next_r.por_done = 1'b0;
      next_r.cfg_done = 1'b0;
      next_r.train_ready = 1'b0;
    end
    // Transceivers follow the host reset only once the device is out of reset
    next_r.xcvr_rst_n = link.fundamental_reset_in_n && r.por_done;
    next_r.upd_link = (mode_in != LPCS_MODE_OFF) && link.link_active;
    next_r.upd_remote = (mode_in == LPCS_MODE_OFF) && r.cfg_done;
    next_r.fab_link = (mode_in == LPCS_MODE_INIT_UPDATE) && link.link_active
        && !r.cfg_done;
    next_r.traffic = link.link_active && next_r.cfg_done;
    // Sticky: a late L0 stays reported even after the link comes up
    if (!link.link_active && r.st != LPCS_D_SUPPLY
        && r.ms_up >= 8'(LPCS_WAKE_L0_MAX_MS)) begin
      next_r.l0_late = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '{st: LPCS_D_SUPPLY, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign device_reset_n_out = r.por_done;
  assign xcvr_reset_n_out = r.xcvr_rst_n;
  assign config_start_out = r.start;
  assign link_image_update_out = r.upd_link;
  assign remote_upgrade_out = r.upd_remote;
  assign partial_reconfig_en_out = r.cfg_done;
  assign link_fabric_config_en_out = r.fab_link;
  assign link_user_traffic_out = r.traffic;
  assign deadline_miss_out = r.miss;
  assign l0_late_out = r.l0_late;
  assign link.supplies_stable = r.por_done;
  assign link.fabric_config_done = r.cfg_done;
  assign link.train_ready = r.train_ready;
endmodule : lpcs_device
`default_nettype wire

// [rtl/lpcs_host.sv]
/*
  Host end: drives fundamental reset and the training and active link
  phases with the minimum millisecond windows.
  Assumes the device reports supplies stable and training ready.
*/
`timescale 1ns/1ps
`default_nettype none
module lpcs_host
  import lpcs_pkg::*;
#(
  parameter int unsigned TICKS_PER_MS = LPCS_TICKS_PER_MS
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  lpcs_link_if.host link,
  input wire logic power_on_in,
  output logic link_up_out,
  output logic config_done_seen_out
);
  typedef enum logic [1:0] {
    LPCS_H_RESET, LPCS_H_RELEASED, LPCS_H_TRAIN, LPCS_H_ACTIVE
  } lpcs_hstate_type;

  typedef struct packed {
    lpcs_hstate_type st;
    logic [24:0] tick;
    logic [LPCS_MS_W-1:0] ms;
    logic rst_n;
    logic training;
    logic active;
    logic done_seen;
  } lpcs_host_type;

  lpcs_host_type r;
  lpcs_host_type next_r;
  logic ms_pulse;

  always_comb begin
    next_r = r;
    ms_pulse = (r.tick == 25'(TICKS_PER_MS - 1));
    next_r.tick = ms_pulse ? 25'h0000000 : r.tick + 25'h0000001;
    if (ms_pulse && r.ms != {LPCS_MS_W{1'b1}}) begin
      next_r.ms = r.ms + 8'h01;
    end
    case (r.st)
      LPCS_H_RESET: begin
        // Active time counts from power-on so that L0 fits the wake-up budget
        if (r.ms >= 8'(LPCS_RESET_ACTIVE_MIN_MS) && link.supplies_stable) begin
          next_r.st = LPCS_H_RELEASED;
          next_r.rst_n = 1'b1;
          next_r.ms = '0;
          next_r.tick = '0;
        end
      end
      LPCS_H_RELEASED: begin
        if (r.ms >= 8'(LPCS_TRAIN_WAIT_MIN_MS) && link.train_ready) begin
          next_r.st = LPCS_H_TRAIN;
          next_r.training = 1'b1;
        end
      end
      LPCS_H_TRAIN: begin
        if (r.ms >= 8'(LPCS_ACTIVE_WAIT_MIN_MS)) begin
          next_r.st = LPCS_H_ACTIVE;
          next_r.training = 1'b0;
          next_r.active = 1'b1;
        end
      end
      default: begin
      end
    endcase
    next_r.done_seen = link.fabric_config_done;
    if (!power_on_in) begin
      next_r.ms = '0;
      next_r.tick = '0;
      next_r.st = LPCS_H_RESET;
      next_r.rst_n = 1'b0;
      next_r.training = 1'b0;
      next_r.active = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '{st: LPCS_H_RESET, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign link.fundamental_reset_in_n = r.rst_n;
  assign link.link_training = r.training;
  assign link.link_active = r.active;
  assign link_up_out = r.active;
  assign config_done_seen_out = r.done_seen;
endmodule : lpcs_host
`default_nettype wire

// [rtl/lpcs_link_if.sv]
/*
  Interface joining the device end and the host end: fundamental reset,
  supply-good report, configuration done, training and active link flags.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface lpcs_link_if;
  logic fundamental_reset_in_n;
  logic supplies_stable;
  logic fabric_config_done;
  logic train_ready;
  logic link_training;
  logic link_active;

  modport device (
    input fundamental_reset_in_n, link_training, link_active,
    output supplies_stable, fabric_config_done, train_ready
  );
  modport host (
    output fundamental_reset_in_n, link_training, link_active,
    input supplies_stable, fabric_config_done, train_ready
  );
endinterface : lpcs_link_if
`default_nettype wire

// [rtl/lpcs_pkg.sv]
/*
  Shared constants and types for the link power-up and configuration
  sequencer: the device end and the host end of the fundamental reset.
  Assumes a single 25 MHz system clock on both ends.
*/
package lpcs_pkg;
  localparam int unsigned LPCS_CLK_HZ = 25000000;
  localparam int unsigned LPCS_TICKS_PER_MS = LPCS_CLK_HZ / 1000;
  localparam int unsigned LPCS_MS_W = 8;
  // Power-on-reset delay windows, in ms
  localparam int unsigned LPCS_FAST_POR_MIN_MS = 4;
  localparam int unsigned LPCS_FAST_POR_MAX_MS = 12;
  localparam int unsigned LPCS_FAST_POR_MS = 8;
  localparam int unsigned LPCS_SLOW_POR_MS = 100;
  // Link deadlines, in ms from power-up
  localparam int unsigned LPCS_TRAIN_READY_MAX_MS = 120;
  localparam int unsigned LPCS_CONFIG_DONE_MAX_MS = 120;
  localparam int unsigned LPCS_WAKE_L0_MAX_MS = 200;
  // Host fundamental reset windows, in ms
  localparam int unsigned LPCS_RESET_ACTIVE_MIN_MS = 100;
  localparam int unsigned LPCS_TRAIN_WAIT_MIN_MS = 20;
  localparam int unsigned LPCS_ACTIVE_WAIT_MIN_MS = 100;

  typedef enum logic [1:0] {
    LPCS_MODE_OFF,
    LPCS_MODE_INIT_UPDATE,
    LPCS_MODE_UPDATE_ONLY
  } lpcs_mode_type;
endpackage : lpcs_pkg

// [tb/lpcs_link_sva.sv]
/* Checker on the fundamental reset link between the host and device ends.
   Assumes one clock; the bench instantiates it beside the link interface. */
`timescale 1ns/1ps
`default_nettype none
module lpcs_link_sva
  import lpcs_pkg::*;
#(
  parameter int unsigned TICKS_PER_MS = LPCS_TICKS_PER_MS
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic fundamental_reset_in_n,
  input wire logic supplies_stable,
  input wire logic fabric_config_done,
  input wire logic train_ready,
  input wire logic link_training,
  input wire logic link_active
);
  int lo_cnt;
  int hi_cnt;
  // Saturated so that a long idle stretch cannot wrap a window
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lo_cnt <= 0;
      hi_cnt <= 0;
    end else begin
      lo_cnt <= fundamental_reset_in_n ? 0 : lo_cnt + ((lo_cnt < 99999) ? 1 : 0);
      hi_cnt <= !fundamental_reset_in_n ? 0 : hi_cnt + ((hi_cnt < 99999) ? 1 : 0);
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_rst_min; $rose(fundamental_reset_in_n) |-> lo_cnt >= 100 * TICKS_PER_MS; endproperty
  a_rst_min: assert property (p_rst_min) else $error("reset released early");
  property p_rel_stable; $rose(fundamental_reset_in_n) |-> supplies_stable; endproperty
  a_rel_stable: assert property (p_rel_stable) else $error("released unstable");
  property p_train_wait; $rose(link_training) |-> hi_cnt >= 20 * TICKS_PER_MS; endproperty
  a_train_wait: assert property (p_train_wait) else $error("training early");
  property p_train_rdy; $rose(link_training) |-> train_ready && fundamental_reset_in_n; endproperty
  a_train_rdy: assert property (p_train_rdy) else $error("training unready");
  property p_active_wait; $rose(link_active) |-> hi_cnt >= 100 * TICKS_PER_MS; endproperty
  a_active_wait: assert property (p_active_wait) else $error("active early");
  property p_active_order; $rose(link_active) |-> $past(link_training); endproperty
  a_active_order: assert property (p_active_order) else $error("active untrained");
  property p_done_rdy; $rose(fabric_config_done) |-> train_ready; endproperty
  a_done_rdy: assert property (p_done_rdy) else $error("done before ready");
  property p_rdy_por; $rose(train_ready) |-> supplies_stable; endproperty
  a_rdy_por: assert property (p_rdy_por) else $error("ready before por");
endmodule : lpcs_link_sva
`default_nettype wire

// [tb/tb.sv]
/* Bench joining device and host ends over the link interface.
   Assumes the rtl package and interface; windows scaled to 10 ticks per ms. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lpcs_pkg::*;
  localparam int unsigned T = 10;
  logic sys_clk_in = 0, reset_n_in = 0, sup = 0, fast = 0, pd = 0, fd = 0, fl = 0, pwr = 0;
  lpcs_mode_type mode = LPCS_MODE_OFF;
  logic drst_n, xrst_n, img, rsu, pr, lfc, ut, miss, up, seen, l0;
  int errors = 0, samples_checked = 0;
  lpcs_link_if link ();
  lpcs_device #(.TICKS_PER_MS(T)) lpcs_device_inst (.sys_clk_in, .reset_n_in, .link(link),
    .supplies_good_in(sup), .fast_por_select_in(fast), .mode_in(mode), .periphery_done_in(pd),
    .full_config_done_in(fd), .fabric_loaded_in(fl), .device_reset_n_out(drst_n),
    .xcvr_reset_n_out(xrst_n), .config_start_out(), .link_image_update_out(img),
    .remote_upgrade_out(rsu), .partial_reconfig_en_out(pr), .link_fabric_config_en_out(lfc),
    .link_user_traffic_out(ut), .deadline_miss_out(miss), .l0_late_out(l0));
  lpcs_host #(.TICKS_PER_MS(T)) lpcs_host_inst (.sys_clk_in, .reset_n_in, .link(link),
    .power_on_in(pwr), .link_up_out(up), .config_done_seen_out(seen));
  lpcs_link_sva #(.TICKS_PER_MS(T)) lpcs_link_sva_inst (.sys_clk_in, .reset_n_in,
    .fundamental_reset_in_n(link.fundamental_reset_in_n), .supplies_stable(link.supplies_stable),
    .fabric_config_done(link.fabric_config_done), .train_ready(link.train_ready),
    .link_training(link.link_training), .link_active(link.link_active));
  initial forever #20 sys_clk_in = ~sys_clk_in;
  task chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t: got %b want %b", $time, got, exp);
    end
  endtask : chk
  task conclude;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  function automatic logic sig(input int w);
    case (w)
      0: return drst_n;
      1: return link.train_ready;
      default: return up;
    endcase
  endfunction : sig
  task automatic wt(input int w, input int lim, output int n);
    n = 0;
    while (sig(w) !== 1'b1) begin
      @(negedge sys_clk_in);
      n++;
      if (n > lim) begin
        errors++;
        $display("FAIL %0t: wait timed out", $time);
        conclude();
      end
    end
  endtask : wt
  // One power-up; cfg_ms is the configuration time after the delay ends
  task automatic run(input lpcs_mode_type m, input logic f, input int cfg_ms, input logic bad);
    int n;
    @(negedge sys_clk_in);
    reset_n_in = 0;
    sup = 0;
    pd = 0;
    fd = 0;
    fl = 0;
    mode = m;
    fast = f;
    repeat (10) @(negedge sys_clk_in);
    reset_n_in = 1;
    pwr = 1;
    repeat (5 * T) @(negedge sys_clk_in);
    chk(drst_n, 0);
    chk(link.fundamental_reset_in_n, 0);
    sup = 1;
    wt(0, 200 * T, n);
    chk(!f || (n >= 4 * T && n <= 12 * T), 1);
    chk(xrst_n, 0);
    repeat (cfg_ms * T) @(negedge sys_clk_in);
    if (m == LPCS_MODE_INIT_UPDATE) pd = 1;
    else fd = 1;
    wt(1, 20 * T, n);
    chk(link.fabric_config_done, m != LPCS_MODE_INIT_UPDATE);
    chk(miss, bad);
    wt(2, 400 * T, n);
    // Link-derived outputs are registered one cycle after the active flag
    @(negedge sys_clk_in);
    chk(xrst_n, 1);
    if (f) chk(l0, 0);
    chk(img, m != LPCS_MODE_OFF);
    chk(rsu, m == LPCS_MODE_OFF);
    chk(pr, m != LPCS_MODE_INIT_UPDATE);
    chk(ut, m != LPCS_MODE_INIT_UPDATE);
    chk(lfc, m == LPCS_MODE_INIT_UPDATE);
    if (m == LPCS_MODE_INIT_UPDATE) begin
      fl = 1;
      repeat (3) @(negedge sys_clk_in);
      chk(link.fabric_config_done, 1);
      chk(seen, 1);
      chk(pr, 1);
      chk(ut, 1);
    end
  endtask : run
  initial begin
    run(LPCS_MODE_OFF, 1, 2, 0);
    run(LPCS_MODE_INIT_UPDATE, 1, 2, 0);
    run(LPCS_MODE_UPDATE_ONLY, 0, 5, 0);
    // Slow delay plus late configuration crosses the deadline
    run(LPCS_MODE_OFF, 0, 30, 1);
    conclude();
  end
endmodule : tb
`default_nettype wire
